/* core/sas_pkg.sv */
package sas_pkg;
   // apb window
   localparam int             APB_AW      = 8;
   localparam int             APB_DW      = 32;
   localparam logic [7:0]     OFF_CTRL    = 8'h00;
   localparam logic [7:0]     OFF_STAT    = 8'h04;
   localparam logic [7:0]     OFF_RES0    = 8'h20;
   localparam logic [7:0]     WORD_MASK   = 8'h03;
   localparam int             WORD_SH     = 2;

   // control register fields
   localparam int             CTRL_W      = 8;
   localparam int             CTRL_START  = 0;
   localparam int             CTRL_DIV_LO = 1;
   localparam int             CTRL_PRI_LO = 3;
   localparam int             CTRL_ALT    = 5;
   localparam int             CTRL_RES8   = 6;
   localparam int             CTRL_VREF   = 7;
   localparam logic [7:0]     CTRL_RST    = 8'h00;

   // status register fields
   localparam int             STAT_BUSY   = 0;
   localparam int             STAT_CH_LO  = 1;
   localparam int             STAT_IRQ    = 4;

   // operating clock select, divided down from the source clock
   localparam logic [1:0]     DIV_BY4     = 2'h0;
   localparam logic [1:0]     DIV_BY2     = 2'h1;
   localparam int             DIV_SH4     = 2;
   localparam int             DIV_SH2     = 1;
   localparam int             PER_W       = 8;

   // successive approximation
   localparam int             RES_W       = 10;
   localparam int             BIT_W       = 4;
   localparam logic [9:0]     SAR_INIT    = 10'h200;
   localparam logic [9:0]     SAR_ONE     = 10'h001;
   localparam logic [3:0]     SAR_MSB     = 4'h9;
   localparam logic [3:0]     LSB_10      = 4'h0;
   localparam logic [3:0]     LSB_8       = 4'h2;
   localparam int             NUM_ALT     = 5;

   // clock
   localparam int             CLK_PER_NS  = 5;

   typedef enum logic {S_IDLE, S_CONV} sas_state_t;
endpackage

/* core/sas_top.sv */
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RL1] start flag begins with channel zero
// [RL2] first channel result lands in result zero
// [RL3] priority pins, one other pin, restart
// [RL4] priority group is one to four channels
// [RL5] every finished pin writes its own result
// [RL6] sweep never raises conversion request bit
// [RL7] sweeping continues until start flag cleared
// [RL8] operating clock source over four, two, one
// [RL9] alternate group replaces channels zero to four
// [RL10] software changes setup only while stopped
// [RL11] software waits after reference connect
// [RL12] software writes mode before pin selection
// [RL13] software waits completion before reading results
// [RL14] software runs processor undivided in repeat
// [RL15] low supply: undivided, no hold, 8-bit
// [RL16] approximation starts at 1000000000, decides bit 9
// [RL17] each lower bit set, compared, maybe cleared
// [RL18] result moves only after last bit decided (bit 2 in 8-bit)
// [RL19] comparison code follows approximation register
// [RL20] 8-bit mode keeps upper eight bits
// [RL21] one result register per channel
module sas_top #(
   parameter int NUM_CH  = 8,
   parameter int SRC_DIV = 4
) (
   input  wire logic                         CLK,
   input  wire logic                         RST_N,
   input  wire logic                         PSEL,
   input  wire logic                         PENABLE,
   input  wire logic                         PWRITE,
   input  wire logic [sas_pkg::APB_AW-1:0]   PADDR,
   input  wire logic [sas_pkg::APB_DW-1:0]   PWDATA,
   output logic      [sas_pkg::APB_DW-1:0]   PRDATA,
   output logic                              PREADY,
   output logic                              PSLVERR,
   input  wire logic                         COMP_IN,
   output logic      [sas_pkg::RES_W-1:0]    DAC_CODE,
   output logic      [$clog2(NUM_CH)-1:0]    CH_SEL,
   output logic                              ALT_SEL,
   output logic                              VREF_CONN,
   output logic                              BUSY
);
   import sas_pkg::*;

   localparam int CH_W = $clog2(NUM_CH);
   localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);
   localparam logic [CH_W-1:0] CH_ONE  = CH_W'(1);

   ////////////////////////////////////////////////////////////////////////
   logic                 comp_meta;
   logic                 comp_sync;

   // comparator output is analog-side, treat as asynchronous
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         comp_meta <= COMP_IN;
         comp_sync <= comp_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [CTRL_W-1:0]    ctrl;
   logic [CTRL_W-1:0]    next_ctrl;
   logic [APB_DW-1:0]    rdata;
   logic [APB_DW-1:0]    next_rdata;
   logic                 slverr;
   logic                 next_slverr;
   logic [RES_W-1:0]     res [NUM_CH];
   logic [RES_W-1:0]     next_res [NUM_CH];
   logic                 res_we;
   logic [RES_W-1:0]     res_data;
   sas_state_t           state;
   sas_state_t           next_state;
   logic [CH_W-1:0]      ch;
   logic [CH_W-1:0]      next_ch;

   logic                 start;
   logic [1:0]           div_sel;
   logic [CH_W-1:0]      prio_last;
   logic                 res8;
   logic                 res_hit;
   logic [APB_AW-1:0]    res_off;
   logic [CH_W-1:0]      res_idx;

   assign start     = ctrl[CTRL_START];
   assign div_sel   = ctrl[CTRL_DIV_LO +: 2];
   assign prio_last = CH_W'(ctrl[CTRL_PRI_LO +: 2]);              // [RL4]
   assign res8      = ctrl[CTRL_RES8];

   assign res_off = PADDR - OFF_RES0;
   assign res_idx = CH_W'(res_off >> WORD_SH);
   assign res_hit = (PADDR >= OFF_RES0) && ((PADDR & WORD_MASK) == '0)
                    && ((res_off >> WORD_SH) < APB_AW'(NUM_CH));

   // zero-wait slave; read data prepared in the setup cycle
   always_comb begin
      next_ctrl   = ctrl;
      next_rdata  = rdata;
      next_slverr = 1'b0;
      if (PSEL && PENABLE && PWRITE && PADDR == OFF_CTRL) begin
         next_ctrl = PWDATA[CTRL_W-1:0];
      end
      if (PSEL && !PENABLE) begin
         next_rdata = '0;
         if (PADDR == OFF_CTRL) begin
            next_rdata[CTRL_W-1:0] = ctrl;
         end else if (PADDR == OFF_STAT) begin
            next_rdata[STAT_BUSY]            = (state == S_CONV);
            next_rdata[STAT_CH_LO +: CH_W]   = ch;
            next_rdata[STAT_IRQ]             = 1'b0;              // [RL6]
         end else if (res_hit) begin
            next_rdata[RES_W-1:0] = res[res_idx];
         end else begin
            next_slverr = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl   <= CTRL_RST;
         rdata  <= '0;
         slverr <= 1'b0;
      end else begin
         ctrl   <= next_ctrl;
         rdata  <= next_rdata;
         slverr <= next_slverr;
      end
   end

   assign PRDATA  = rdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = slverr && PSEL && PENABLE;

   ////////////////////////////////////////////////////////////////////////
   // operating clock as a step strobe, no derived clock net
   logic [PER_W-1:0]     period;
   logic [PER_W-1:0]     cnt;
   logic [PER_W-1:0]     next_cnt;
   logic                 tick;

   always_comb begin
      unique case (div_sel)                                        // [RL8]
         DIV_BY4: period = PER_W'(SRC_DIV) << DIV_SH4;
         DIV_BY2: period = PER_W'(SRC_DIV) << DIV_SH2;
         default: period = PER_W'(SRC_DIV);
      endcase
   end

   assign tick = (state == S_CONV) && (cnt == period - PER_W'(1));

   always_comb begin
      next_cnt = cnt + PER_W'(1);
      if (state != S_CONV || tick) begin
         next_cnt = '0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [RES_W-1:0]     sar;
   logic [RES_W-1:0]     next_sar;
   logic [BIT_W-1:0]     bitidx;
   logic [BIT_W-1:0]     next_bitidx;
   logic [CH_W-1:0]      nx;
   logic [CH_W-1:0]      next_nx;
   logic                 in_nx;
   logic                 next_in_nx;
   logic                 alt_sel;
   logic                 next_alt_sel;
   logic [RES_W-1:0]     decided;
   logic [BIT_W-1:0]     last_bit;

   assign last_bit = res8 ? LSB_8 : LSB_10;
   // keep the bit only when the comparison voltage is below the input
   assign decided  = comp_sync ? sar : (sar & ~(SAR_ONE << bitidx)); // [RL17]

   always_comb begin
      next_state  = state;
      next_sar    = sar;
      next_bitidx = bitidx;
      next_ch     = ch;
      next_nx     = nx;
      next_in_nx  = in_nx;
      res_we      = 1'b0;
      res_data    = decided;
      if (res8) begin
         res_data = RES_W'(decided[RES_W-1:LSB_8]);               // [RL20]
      end
      unique case (state)
         S_IDLE: begin
            if (start) begin                                       // [RL1]
               next_state  = S_CONV;
               next_sar    = SAR_INIT;                             // [RL16]
               next_bitidx = SAR_MSB;
               next_ch     = '0;
               next_in_nx  = 1'b0;
               next_nx     = prio_last + CH_ONE;
            end
         end
         S_CONV: begin
            // dropping the flag aborts, a partial result is discarded
            if (!start) begin                                      // [RL7]
               next_state = S_IDLE;
               next_sar   = SAR_INIT;
            end else if (tick) begin
               if (bitidx == last_bit) begin
                  res_we      = 1'b1;                              // [RL18]
                  next_sar    = SAR_INIT;
                  next_bitidx = SAR_MSB;
                  if (in_nx) begin                                 // [RL3]
                     next_ch    = '0;
                     next_in_nx = 1'b0;
                     next_nx    = (nx == CH_LAST) ? prio_last + CH_ONE
                                                  : nx + CH_ONE;
                  end else if (ch == prio_last) begin
                     next_ch    = nx;
                     next_in_nx = 1'b1;
                  end else begin
                     next_ch    = ch + CH_ONE;
                  end
               end else begin
                  next_sar    = decided | (SAR_ONE << (bitidx - 1'b1));
                  next_bitidx = bitidx - 1'b1;
               end
            end
         end
      endcase
      next_alt_sel = next_ctrl[CTRL_ALT] && (next_ch < CH_W'(NUM_ALT));
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state   <= S_IDLE;
         sar     <= SAR_INIT;
         bitidx  <= SAR_MSB;
         ch      <= '0;
         nx      <= '0;
         in_nx   <= 1'b0;
         alt_sel <= 1'b0;
      end else begin
         state   <= next_state;
         sar     <= next_sar;
         bitidx  <= next_bitidx;
         ch      <= next_ch;
         nx      <= next_nx;
         in_nx   <= next_in_nx;
         alt_sel <= next_alt_sel;
      end
   end

   // each channel owns a result word, touched only at its own completion
   always_comb begin
      next_res = res;
      if (res_we) begin
         next_res[ch] = res_data;                            // [RL2] [RL5]
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < NUM_CH; i++) begin
            res[i] <= '0;                                          // [RL21]
         end
      end else begin
         res <= next_res;
      end
   end

   assign DAC_CODE  = sar;                                         // [RL19]
   assign CH_SEL    = ch;
   assign ALT_SEL   = alt_sel;                                     // [RL9]
   assign VREF_CONN = ctrl[CTRL_VREF];
   assign BUSY      = (state == S_CONV);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   logic [PER_W-1:0]     gap;
   logic [PER_W-1:0]     next_gap;
   logic [RES_W-1:0]     sar_q;
   logic [CH_W-1:0]      ch_q;

   // step length seen from the outputs, not from the divider counter
   always_comb begin
      next_gap = gap + PER_W'(1);
      if (!BUSY) begin
         next_gap = '0;
      end else if (sar != sar_q || ch != ch_q) begin
         next_gap = PER_W'(1);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gap   <= '0;
         sar_q <= SAR_INIT;
         ch_q  <= '0;
      end else begin
         gap   <= next_gap;
         sar_q <= sar;
         ch_q  <= ch;
      end
   end

   a_start_ch0: assert property (                                  // [RL1]
      state == S_IDLE && start |=> BUSY && CH_SEL == '0 && !in_nx)
      else $error("start did not begin at channel zero");
   a_first_result: assert property (                               // [RL2]
      res_we && ch == '0 |=> res[0] == $past(res_data))
      else $error("channel zero result not stored");
   a_sweep_wrap: assert property (                                 // [RL3]
      res_we && in_nx && start |=> CH_SEL == '0 ##0 !in_nx)
      else $error("sweep did not restart after extra pin");
   a_prio_range: assert property (                                 // [RL4]
      BUSY && !in_nx |-> ch <= prio_last)
      else $error("priority channel out of group");
   a_other_pin: assert property (                                  // [RL3]
      BUSY && in_nx |-> ch > prio_last)
      else $error("extra pin taken from priority group");
   a_result_dest: assert property (                                // [RL5]
      res_we |=> res[$past(ch)] == $past(res_data))
      else $error("result went to wrong register");
   a_no_irq: assert property (                                     // [RL6]
      PSEL && !PENABLE && PADDR == OFF_STAT |=> !PRDATA[STAT_IRQ])
      else $error("conversion request bit set in sweep");
   a_keep_sweep: assert property (                                 // [RL7]
      BUSY && start |=> BUSY)
      else $error("sweep stopped with start flag set");
   a_stop_sweep: assert property (                                 // [RL7]
      BUSY && !start |=> !BUSY ##1 !BUSY || start)
      else $error("sweep kept running after flag cleared");
   a_div_period: assert property (                                 // [RL8]
      tick |-> gap == period - PER_W'(1))
      else $error("comparison step not at operating clock");
   a_alt_route: assert property (                                  // [RL9]
      ALT_SEL |-> ctrl[CTRL_ALT] && ch < CH_W'(NUM_ALT))
      else $error("alternate input used outside channels 0-4");
   a_sar_init: assert property (                                   // [RL16]
      $rose(BUSY) |-> DAC_CODE == SAR_INIT && bitidx == SAR_MSB)
      else $error("approximation not started at midscale");
   a_bit_clear: assert property (                                  // [RL17]
      tick && start && bitidx != last_bit && !comp_sync
      |=> !sar[$past(bitidx)] && sar[$past(bitidx) - 1'b1])
      else $error("bit not cleared or next bit not trialed");
   a_result_done: assert property (                                // [RL18]
      res_we |-> tick && bitidx == last_bit)
      else $error("result moved before last bit decided");
   a_res_8bit: assert property (                                   // [RL20]
      res_we && res8 |-> res_data[RES_W-1:RES_W-2] == '0)
      else $error("8-bit result not right-aligned");
   a_res_hold: assert property (                                   // [RL21]
      !(res_we && ch == '0) |=> $stable(res[0]))
      else $error("result zero changed without completion");
endmodule
`default_nettype wire

/* tb/sas_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// analog pins behind the comparator; pin at code k sits at 2k+1 half-lsbs,
// right on the code k+1 threshold, and the strict compare makes the ideal result exactly k
module sas_analog_model (
   input  wire logic [9:0] dac_code,
   input  wire logic [2:0] ch_sel,
   input  wire logic       alt_sel,
   output logic            comp_in
);
   int v;
   always_comb begin
      v = 2 * (100 * int'(ch_sel) + 37) + 1;
      if (alt_sel && ch_sel < 3'h5) begin
         v = 2 * (100 * int'(ch_sel) + 53) + 1;
      end
      // code 0 compares against ground
      comp_in = (dac_code == 10'h000) ? (v > 0)
                                      : (2 * int'(dac_code) - 1 < v);
   end
endmodule
`default_nettype wire

/* tb/sar_adc_sweep_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sweep_sequencer_tb_top;
   import sas_pkg::*;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, comp_in, alt_sel, vref_conn, busy;
   logic [9:0]  dac_code;
   logic [2:0]  ch_sel;
   int          fail_count = 0;
   int          checked    = 0;
   // control setup beside the channel order it must produce, one nibble each
   logic [7:0]  row_ctrl [4] = '{8'h00, 8'h4a, 8'h74, 8'h1e};
   logic [23:0] row_seq  [4] = '{24'h010203, 24'h012013, 24'h012301,
                                 24'h012340};

   always #2.5 clk = ~clk;

   sas_top #(.NUM_CH(8), .SRC_DIV(3)) dut (
      .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .COMP_IN(comp_in),
      .DAC_CODE(dac_code), .CH_SEL(ch_sel), .ALT_SEL(alt_sel),
      .VREF_CONN(vref_conn), .BUSY(busy));

   sas_analog_model pm (.dac_code(dac_code), .ch_sel(ch_sel),
                        .alt_sel(alt_sel), .comp_in(comp_in));

   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // a bound that runs out ends the run
   task limit(input int n, input int lim);
      if (n >= lim) begin
         check(32'(n), 32'(lim - 1));
         print_verdict();
      end
   endtask

   // entered right after a rising edge; idle edge at the end keeps psel
   // from being driven twice in one step by back to back calls
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      limit(n, 20);
      @(posedge clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, a, 32'h0, rd, e);
      check(rd, exp);
      check(32'(e), 32'h0);
   endtask

   task wait_busy(input logic lvl, output int n);
      n = 0;
      while (busy !== lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      limit(n, 400);
   endtask

   task wait_ch(output int n);
      logic [2:0] prev;
      prev = ch_sel;
      n = 0;
      while (ch_sel === prev && n < 2000) begin
         @(posedge clk);
         n++;
      end
      limit(n, 2000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int          n, per, steps, k;
      logic [2:0]  ch;
      logic [31:0] rd;
      logic        e;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(32'(dac_code), 32'h200);
      check(32'(busy), 32'h0);
      rdchk(OFF_CTRL, 32'h0);
      $display("test reset done");

      for (int r = 0; r < 4; r++) begin
         wr(OFF_CTRL, {24'h0, row_ctrl[r]});
         wr(OFF_CTRL, {24'h0, row_ctrl[r] | 8'h01});
         wait_busy(1'b1, n);
         check(32'(ch_sel), 32'h0);
         check(32'(dac_code), 32'h200);
         check(32'(alt_sel), 32'(row_ctrl[r][CTRL_ALT]));
         per = 3 * ((row_ctrl[r][2:1] == DIV_BY4) ? 4 :
                    (row_ctrl[r][2:1] == DIV_BY2) ? 2 : 1);
         steps = row_ctrl[r][CTRL_RES8] ? 8 : 10;
         for (int j = 1; j < 6; j++) begin
            wait_ch(n);
            ch = row_seq[r][22 - 4 * j -: 3];
            if (j == 1)
               check(32'(n), 32'(steps * per));
            check(32'(ch_sel), 32'(ch));
            check(32'(busy), 32'h1);
         end
         apb(1'b0, OFF_STAT, 32'h0, rd, e);
         check(32'(rd[STAT_IRQ]), 32'h0);
         wr(OFF_CTRL, {24'h0, row_ctrl[r]});
         wait_busy(1'b0, n);
         check(32'(n <= 3), 32'h1);
         for (int j = 0; j < 5; j++) begin
            ch = row_seq[r][22 - 4 * j -: 3];
            k = (row_ctrl[r][CTRL_ALT] && ch < 3'h5) ? 100 * ch + 53
                                                     : 100 * ch + 37;
            if (row_ctrl[r][CTRL_RES8])
               k = k >> 2;
            rdchk(OFF_RES0 + 8'(4 * ch), 32'(k));
         end
         $display("test row %0d done", r);
      end

      apb(1'b0, 8'h10, 32'h0, rd, e);
      check(32'(e), 32'h1);
      check(rd, 32'h0);
      check(32'(pready), 32'h1);
      $display("test unmapped done");

      wr(OFF_CTRL, 32'h80);
      check(32'(vref_conn), 32'h1);
      repeat (200) @(posedge clk);
      wr(OFF_CTRL, 32'h85);
      wait_busy(1'b1, n);
      n = 0;
      while (dac_code === 10'h200 && n < 50) begin
         @(posedge clk);
         n++;
      end
      limit(n, 50);
      check(32'(dac_code), 32'h100);
      rst_n <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      check(32'(busy), 32'h0);
      check(32'(ch_sel), 32'h0);
      check(32'(dac_code), 32'h200);
      check(32'(vref_conn), 32'h0);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(OFF_CTRL, 32'h0);
      $display("test reference and mid-run reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
